// ===== logic/parallel_page_program_seq.sv
// Purpose: tail of the parallel flash page program sequence, device side
// Assumes: programmer keeps strobes quiet while busy; pins asynchronous
// Notes:   page write time is a fixed count of mclk_i cycles
//
// What this block does
// (R01) Action code 00 makes the next load strobe an address byte load.
// (R02) During an address load a byte-select of one steers the byte to the high half.
// (R03) A rising load strobe latches the selected address byte from the data bus.
// (R04) A falling write strobe while writing is enabled starts a page write and drives ready/busy low.
// (R05) The programmer waits for ready/busy high before continuing.
// (R06) The programmer repeats the steps for every page it writes.
// (R07) Action code 10 makes the next load strobe a command load.
// (R08) An all-zero command byte is decoded as no operation.
// (R09) Latching the no-operation command clears all internal write controls.
// (R10) The programmer issues no strobes while ready/busy is low.
`timescale 1ns/1ps
`default_nettype none
module parallel_page_program_seq (
   // clock and reset
   input  wire logic       mclk_i,
   input  wire logic       rst_i,
   // programmer pins
   input  wire logic       action_select_high_i,
   input  wire logic       action_select_low_i,
   input  wire logic       byte_half_select_i,
   input  wire logic       load_strobe_pin_i,
   input  wire logic       write_strobe_n_i,
   input  wire logic [7:0] data_i,
   // status and flash side
   output logic            ready_busy_out_o,
   output logic [7:0]      addr_high_o,
   output logic [7:0]      addr_low_o,
   output logic [7:0]      command_o,
   output logic            write_enable_o,
   output logic            page_write_o
);
   import ppseq_pkg::*;

   typedef enum logic [0:0] {
      ST_READY = 1'b0,
      ST_BUSY  = 1'b1
   } state_e;

   ppseq_sync_if sync ();

   state_e     state_q;
   logic       load_prev_q;
   logic       wr_prev_q;
   logic [9:0] count_q;
   logic       load_rise;
   logic       wr_fall;
   logic       addr_load;
   logic       cmd_load;

   // action pins against an action code
   function automatic logic act_is(input logic hi, input logic lo, input logic [1:0] code);
      return {hi, lo} == code;
   endfunction

   ppseq_pin_sync u_sync (
      .mclk_i (mclk_i),
      .rst_i  (rst_i),
      .pins_i ({action_select_high_i, action_select_low_i, byte_half_select_i,
                load_strobe_pin_i, write_strobe_n_i, data_i}),
      .sync   (sync)
   );

   // ----------------------------------------------------------------
   // strobe edges
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         load_prev_q <= 1'b0;
         wr_prev_q   <= 1'b1;
      end else begin
         load_prev_q <= sync.load_lvl;
         wr_prev_q   <= sync.wr_n_lvl;
      end
   end

   assign load_rise = sync.load_lvl & ~load_prev_q;           // see (R03)
   assign wr_fall   = ~sync.wr_n_lvl & wr_prev_q;
   assign addr_load = load_rise && act_is(sync.act_high, sync.act_low, ACT_ADDR); // see (R01)
   assign cmd_load  = load_rise && state_q == ST_READY                 // see (R10)
                      && act_is(sync.act_high, sync.act_low, ACT_CMD); // see (R07)

   // ----------------------------------------------------------------
   // address and command latches
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         addr_high_o <= RESET_BYTE;
         addr_low_o  <= RESET_BYTE;
      end else if (addr_load) begin                           // see (R01)
         if (sync.half_sel) begin
            addr_high_o <= sync.data;                        // see (R02)
         end else begin
            addr_low_o <= sync.data;
         end
      end
   end

   // ignored while busy, programmer must hold off
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         command_o      <= CMD_NOP;
         write_enable_o <= 1'b0;
      end else if (cmd_load) begin                            // see (R07) see (R10)
         command_o <= sync.data;
         if (sync.data == CMD_NOP) begin                      // see (R08)
            write_enable_o <= 1'b0;                           // see (R09)
         end else begin
            write_enable_o <= (sync.data == CMD_WRITE_FLASH);
         end
      end
   end

   // ----------------------------------------------------------------
   // page write timer
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         state_q          <= ST_READY;
         count_q          <= 10'h000;
         ready_busy_out_o <= 1'b1;
         page_write_o     <= 1'b0;
      end else begin
         unique case (state_q)
            ST_READY: begin
               if (wr_fall && write_enable_o) begin          // see (R04)
                  state_q          <= ST_BUSY;
                  count_q          <= PROG_COUNT;
                  ready_busy_out_o <= 1'b0;
                  page_write_o     <= 1'b1;
               end
            end
            ST_BUSY: begin
               if (count_q == 10'h001) begin                  // see (R05)
                  state_q          <= ST_READY;
                  ready_busy_out_o <= 1'b1;
                  page_write_o     <= 1'b0;
               end
               count_q <= count_q - 10'h001;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   busy_on_write_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see (R04)
      (state_q == ST_READY && wr_fall && write_enable_o) |=> !ready_busy_out_o)
      else $error("write strobe did not start busy");

   busy_length_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see (R05)
      $fell(ready_busy_out_o) |-> !ready_busy_out_o [*8])
      else $error("busy ended too early");

   busy_ends_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see (R05)
      $fell(ready_busy_out_o) |-> ##[1:60] ready_busy_out_o)
      else $error("busy never ended");

   addr_high_load_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see (R02)
      (load_rise && {sync.act_high, sync.act_low} == ACT_ADDR && sync.half_sel)
      |=> addr_high_o == $past(sync.data))
      else $error("high address byte not latched");

   addr_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see (R01)
      ({sync.act_high, sync.act_low} != ACT_ADDR) |=> $stable(addr_high_o))
      else $error("address changed outside address load");

   addr_low_load_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see (R03)
      (load_rise && {sync.act_high, sync.act_low} == ACT_ADDR && !sync.half_sel)
      |=> addr_low_o == $past(sync.data) && $stable(addr_high_o))
      else $error("low address byte wrongly latched");

   nop_clears_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see (R09)
      (load_rise && state_q == ST_READY && {sync.act_high, sync.act_low} == ACT_CMD
       && sync.data == CMD_NOP) |=> !write_enable_o && command_o == CMD_NOP)
      else $error("no-op did not clear write controls");

   cmd_load_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see (R07)
      (load_rise && state_q == ST_READY && {sync.act_high, sync.act_low} == ACT_CMD)
      |=> command_o == $past(sync.data))
      else $error("command not latched");

   status_match_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see (R04)
      page_write_o == !ready_busy_out_o)
      else $error("page write and ready disagree");

   other_action_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see (R01) see (R07)
      (load_rise && !act_is(sync.act_high, sync.act_low, ACT_ADDR)
       && !act_is(sync.act_high, sync.act_low, ACT_CMD))
      |=> $stable(addr_high_o) && $stable(addr_low_o) && $stable(command_o))
      else $error("data load changed a latch");

   busy_refuse_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see (R10)
      (state_q == ST_BUSY) |=> $stable(command_o) && $stable(write_enable_o))
      else $error("command taken while busy");

   busy_start_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see (R04)
      $fell(ready_busy_out_o) |-> count_q == PROG_COUNT && page_write_o)
      else $error("page write started with wrong count");

   busy_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see (R05)
      (state_q == ST_BUSY && count_q != 10'h001) |=> !ready_busy_out_o)
      else $error("busy dropped before count ran out");

   busy_done_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see (R05)
      (state_q == ST_BUSY && count_q == 10'h001) |=> ready_busy_out_o && !page_write_o)
      else $error("busy did not end at count end");

   ready_stay_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see (R04)
      (state_q == ST_READY && !(wr_fall && write_enable_o)) |=> ready_busy_out_o)
      else $error("busy without an enabled write strobe");

   other_cmd_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see (R07)
      (cmd_load && sync.data != CMD_NOP && sync.data != CMD_WRITE_FLASH)
      |=> !write_enable_o)
      else $error("unknown command enabled writing");
endmodule
`default_nettype wire

// ===== logic/ppseq_pin_sync.sv
// Purpose: two-flop synchroniser for all programmer pins
// Assumes: pins are asynchronous to mclk_i
// Notes:   first stage read by the second stage only
`timescale 1ns/1ps
`default_nettype none
module ppseq_pin_sync (
   input  wire logic       mclk_i,
   input  wire logic       rst_i,
   input  wire logic [12:0] pins_i,
   ppseq_sync_if.src       sync
);
   import ppseq_pkg::*;

   logic [12:0] meta_q;
   logic [12:0] sync_q;

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         meta_q <= PIN_IDLE;
         sync_q <= PIN_IDLE;
      end else begin
         meta_q <= pins_i;
         sync_q <= meta_q;
      end
   end

   assign sync.act_high = sync_q[12];
   assign sync.act_low  = sync_q[11];
   assign sync.half_sel = sync_q[10];
   assign sync.load_lvl = sync_q[9];
   assign sync.wr_n_lvl = sync_q[8];
   assign sync.data     = sync_q[7:0];
endmodule
`default_nettype wire

// ===== logic/ppseq_pkg.sv
// Purpose: constants for the parallel page program sequencer
// Assumes: 10 MHz mclk_i
// Notes:   action codes, commands and timing counts
package ppseq_pkg;
   localparam logic [1:0] ACT_ADDR        = 2'h0;
   localparam logic [1:0] ACT_CMD         = 2'h2;
   localparam logic [7:0] CMD_NOP         = 8'h00;
   localparam logic [7:0] CMD_WRITE_FLASH = 8'h10;
   localparam logic [7:0] RESET_BYTE      = 8'h00;
   // pin idle levels: load strobe low, write strobe high
   localparam logic [12:0] PIN_IDLE       = 13'h0100;
   localparam int         PROG_TIME_US    = 5;
   localparam int         CLK_MHZ         = 10;
   localparam int         PROG_CYCLES     = PROG_TIME_US * CLK_MHZ;
   localparam logic [9:0] PROG_COUNT      = 10'(PROG_CYCLES);
endpackage

// ===== logic/ppseq_sync_if.sv
// Purpose: carries synchronised pin levels into the sequencer core
// Assumes: single clock mclk_i
// Notes:   filled by the pin synchroniser
`timescale 1ns/1ps
`default_nettype none
interface ppseq_sync_if;
   logic       act_high;
   logic       act_low;
   logic       half_sel;
   logic       load_lvl;
   logic       wr_n_lvl;
   logic [7:0] data;
   modport src (output act_high, act_low, half_sel, load_lvl, wr_n_lvl, data);
   modport dst (input  act_high, act_low, half_sel, load_lvl, wr_n_lvl, data);
endinterface
`default_nettype wire

// ===== tb/parallel_page_program_seq_tb.sv
// Purpose: self-checking bench for the page program sequencer
// Assumes: 10 MHz mclk_i, fixed seed
// Notes:   pages of random high bytes, edge bytes first
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module parallel_page_program_seq_tb;
   import ppseq_pkg::*;
   logic       mclk_i = 1'b0;
   logic       rst_i  = 1'b1;
   logic       ah, al, bs, ld, wr_n, rdy, we, pw;
   logic [7:0] d, ahi, alo, cmd, r;
   logic [9:0] cnt;
   int         err_total = 0;
   int         n_checks  = 0;
   int         seed      = 1;
   always #50 mclk_i = ~mclk_i;
   ppseq_prog_model prog (.mclk_i(mclk_i), .ready_i(rdy), .act_hi_o(ah), .act_lo_o(al),
      .half_o(bs), .load_o(ld), .wr_n_o(wr_n), .data_o(d));
   parallel_page_program_seq dut (.mclk_i(mclk_i), .rst_i(rst_i), .action_select_high_i(ah),
      .action_select_low_i(al), .byte_half_select_i(bs), .load_strobe_pin_i(ld),
      .write_strobe_n_i(wr_n), .data_i(d), .ready_busy_out_o(rdy), .addr_high_o(ahi),
      .addr_low_o(alo), .command_o(cmd), .write_enable_o(we), .page_write_o(pw));
   function automatic logic we_of(input logic [7:0] c);
      return c == CMD_WRITE_FLASH;
   endfunction
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // a write strobe without write enable must be ignored
   task automatic refused_write();
      prog.wr_pulse();
      repeat (5) @(negedge mclk_i);
      `CHK({rdy, pw}, 2'h2)
   endtask
   initial begin
      #2_000_000;
      err_total++;
      tally_and_finish();
   end
   initial begin
      repeat (16) @(posedge mclk_i);
      rst_i <= 1'b0;
      @(negedge mclk_i);
      `CHK({rdy, pw, we, cmd, ahi}, 19'h40000)
      refused_write();
      // data and unused action codes latch nothing
      for (int k = 1; k < 4; k += 2) begin
         prog.load_byte(2'(k), 1'b1, 8'($random(seed)));
         `CHK({ahi, alo, cmd}, {RESET_BYTE, RESET_BYTE, CMD_NOP})
      end
      // a command other than write leaves writing disabled
      r = 8'($random(seed)) | 8'h01;
      prog.load_byte(ACT_CMD, 1'b0, r);
      `CHK({cmd, we}, {r, we_of(r)})
      refused_write();
      for (int p = 0; p < 6; p++) begin
         prog.load_byte(ACT_CMD, 1'b0, CMD_WRITE_FLASH);
         `CHK({cmd, we}, {CMD_WRITE_FLASH, we_of(CMD_WRITE_FLASH)})
         r = (p == 0) ? 8'h00 : (p == 1) ? 8'hFF : 8'($random(seed));
         prog.load_byte(ACT_ADDR, 1'b1, r);
         `CHK(ahi, r)
         prog.load_byte(ACT_ADDR, 1'b0, ~r);
         `CHK({ahi, alo}, {r, ~r})
         prog.wr_pulse();
         cnt = 10'h000;
         for (int i = 0; i < 300; i++) begin
            if (rdy === 1'b0) begin
               cnt++;
               `CHK(pw, 1'b1)
            end else if (cnt != 10'h000) break;
            @(negedge mclk_i);
         end
         `CHK(cnt, PROG_COUNT)
      end
      prog.load_byte(ACT_CMD, 1'b0, CMD_NOP);
      `CHK({cmd, we}, {CMD_NOP, we_of(CMD_NOP)})
      refused_write();
      tally_and_finish();
   end
endmodule
`default_nettype wire

// ===== tb/ppseq_prog_model.sv
// Purpose: parallel programmer driving the sequencer pins
// Assumes: pins change just after mclk_i rises
// Notes:   holds every level 3 cycles around each strobe edge
`timescale 1ns/1ps
`default_nettype none
module ppseq_prog_model (
   // clock and status
   input  wire logic       mclk_i,
   input  wire logic       ready_i,
   // programmer pins
   output logic            act_hi_o,
   output logic            act_lo_o,
   output logic            half_o,
   output logic            load_o,
   output logic            wr_n_o,
   output logic [7:0]      data_o
);
   initial begin
      {act_hi_o, act_lo_o, half_o, load_o} = 4'h0;
      wr_n_o = 1'b1;
      data_o = 8'h00;
   end
   // strobes only while ready
   task automatic idle_wait();
      for (int i = 0; i < 300 && ready_i !== 1'b1; i++) @(posedge mclk_i);
   endtask
   task automatic load_byte(input logic [1:0] act, input logic half, input logic [7:0] d);
      idle_wait();
      @(posedge mclk_i);
      {act_hi_o, act_lo_o} <= act;
      half_o <= half;
      data_o <= d;
      repeat (3) @(posedge mclk_i);
      load_o <= 1'b1;
      repeat (3) @(posedge mclk_i);
      load_o <= 1'b0;
      repeat (3) @(posedge mclk_i);
      data_o <= ~d;
      @(negedge mclk_i);
   endtask
   task automatic wr_pulse();
      idle_wait();
      @(posedge mclk_i);
      wr_n_o <= 1'b0;
      repeat (3) @(posedge mclk_i);
      wr_n_o <= 1'b1;
      @(negedge mclk_i);
   endtask
endmodule
`default_nettype wire
